// *** include/probe_latch_params.svh ***
// Constants for the probe latch and input status block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef PROBE_LATCH_PARAMS_SVH
`define PROBE_LATCH_PARAMS_SVH

// ---------------------------------------------------------------
// Service codes
// ---------------------------------------------------------------
`define SVC_GET_SINGLE 8'h0E
`define SVC_SET_SINGLE 8'h10

// ---------------------------------------------------------------
// Object instance numbers
// ---------------------------------------------------------------
`define OBJ_PROBE_COMMAND 16'h60B8
`define OBJ_PROBE_STATUS 16'h60B9
`define OBJ_ONE_RISE 16'h60BA
`define OBJ_ONE_FALL 16'h60BB
`define OBJ_TWO_RISE 16'h60BC
`define OBJ_TWO_FALL 16'h60BD
`define OBJ_INPUT_SNAPSHOT 16'h60FD

// ---------------------------------------------------------------
// Reset values and snapshot fields
// ---------------------------------------------------------------
`define PROBE_COMMAND_RESET 16'h0000
`define POSITION_RESET 32'h0000_0000
`define SNAP_BIT_REVERSE 0
`define SNAP_BIT_FORWARD 1
`define SNAP_BIT_HOME 2
`define SNAP_BIT_PIN_FOUR 20
`define SNAP_BIT_PIN_FIVE 21
`define SNAP_BIT_STO_A 24
`define SNAP_BIT_STO_B 25

// ---------------------------------------------------------------
// Answer status codes
// ---------------------------------------------------------------
`define ANS_OK 8'h00
`define ANS_NOT_SUPPORTED 8'h08
`define ANS_NOT_SETTABLE 8'h0E
`define ANS_NO_OBJECT 8'h16

`endif

// *** include/probe_latch_pkg.sv ***
// Types shared by the probe latch and input status block.
// Assumes the constants header is on the include path.
`default_nettype none
package probe_latch_pkg;

    typedef struct packed {
        logic [7:0] service;
        logic [15:0] object;
        logic [31:0] value;
    } request_t;

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] value;
    } answer_t;

    typedef struct packed {
        logic reverse_stroke_end_input;
        logic forward_stroke_end_input;
        logic home_proximity_input;
        logic input_pin_four;
        logic input_pin_five;
        logic safe_torque_off_chan_a;
        logic safe_torque_off_chan_b;
    } pins_t;

endpackage
`default_nettype wire

// *** hdl/pin_sync.sv ***
// Two-flop synchroniser for a group of input pins.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/1ns
`default_nettype none

module pin_sync
    import probe_latch_pkg::*;
#(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.first = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;

endmodule

`default_nettype wire

// *** hdl/edge_latch.sv ***
// Captures a position word on the rising and falling edges of one probe.
// Assumes the probe level is already synchronised to clock.
`timescale 1ns/1ns
`default_nettype none

module edge_latch
    import probe_latch_pkg::*;
#(
    parameter int POS_WIDTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Probe and position
    input wire logic probe,
    input wire logic enable,
    input wire logic [POS_WIDTH-1:0] position,
    // Captured values
    output logic [POS_WIDTH-1:0] rise_position,
    output logic [POS_WIDTH-1:0] fall_position,
    output logic rise_seen,
    output logic fall_seen
);

    typedef struct packed {
        logic last;
        logic [POS_WIDTH-1:0] rise;
        logic [POS_WIDTH-1:0] fall;
        logic rose;
        logic fell;
    } latch_state_t;

    latch_state_t state;
    latch_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.last = probe;
        // Held until the next qualifying edge
        if (enable && probe && !state.last) begin
            next_state.rise = position;
            next_state.rose = 1'b1;
        end
        if (enable && !probe && state.last) begin
            next_state.fall = position;
            next_state.fell = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise_position = state.rise;
    assign fall_position = state.fall;
    assign rise_seen = state.rose;
    assign fall_seen = state.fell;

endmodule

`default_nettype wire

// *** hdl/probe_latch.sv ***
// Probe position latch and input snapshot, reached by attribute services.
// Assumes one request per strobe on the control clock; pins are async.
`timescale 1ns/1ns
`default_nettype none
`include "probe_latch_params.svh"

module probe_latch
    import probe_latch_pkg::*;
#(
    parameter int POS_WIDTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Attribute service request and answer
    input wire logic req_valid,
    input wire request_t req,
    output logic ans_valid,
    output answer_t ans,
    // Position source, same clock
    input wire logic signed [POS_WIDTH-1:0] actual_position,
    // Input pins
    input wire pins_t pins,
    // Pin four selects probe one when high, launch input when low
    input wire logic input_four_function_param,
    // Launch input seen on pin four
    output logic motion_launch_input
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic ans_valid;
        answer_t ans;
        logic [15:0] probe_command_word;
        logic [31:0] input_pin_snapshot;
        logic launch;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    pins_t pins_sync;
    logic [POS_WIDTH-1:0] one_rise;
    logic [POS_WIDTH-1:0] one_fall;
    logic [POS_WIDTH-1:0] two_rise;
    logic [POS_WIDTH-1:0] two_fall;
    logic one_rose;
    logic one_fell;
    logic two_rose;
    logic two_fell;
    logic probe_input_one;
    logic probe_input_two;
    logic [15:0] probe_status_word;

    // ---------------------------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------------------------
    pin_sync #(
        .WIDTH($bits(pins_t))
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(pins),
        .sync_out(pins_sync)
    );

    // Pin four is probe one only in its probe setting
    assign probe_input_one = pins_sync.input_pin_four &
        input_four_function_param;
    assign probe_input_two = pins_sync.input_pin_five;

    // ---------------------------------------------------------------
    // Capture units
    // ---------------------------------------------------------------
    // Latching is enabled by bit 0 and bit 8 of the command word; the
    // finer command bits are kept for software but not decoded here.
    edge_latch #(
        .POS_WIDTH(POS_WIDTH)
    ) u_probe_one (
        .clock(clock),
        .rst(rst),
        .probe(probe_input_one),
        .enable(state.probe_command_word[0] & input_four_function_param),
        .position(actual_position),
        .rise_position(one_rise),
        .fall_position(one_fall),
        .rise_seen(one_rose),
        .fall_seen(one_fell)
    );

    edge_latch #(
        .POS_WIDTH(POS_WIDTH)
    ) u_probe_two (
        .clock(clock),
        .rst(rst),
        .probe(probe_input_two),
        .enable(state.probe_command_word[8]),
        .position(actual_position),
        .rise_position(two_rise),
        .fall_position(two_fall),
        .rise_seen(two_rose),
        .fall_seen(two_fell)
    );

    // Status: enable and capture flags per probe
    assign probe_status_word = {5'h00, two_fell, two_rose,
        state.probe_command_word[8], 5'h00, one_fell, one_rose,
        state.probe_command_word[0]};

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] snapshot(input pins_t p);
        logic [31:0] w;
        // Reserved bits read as zero
        w = 32'h0000_0000;
        w[`SNAP_BIT_REVERSE] = p.reverse_stroke_end_input;
        w[`SNAP_BIT_FORWARD] = p.forward_stroke_end_input;
        w[`SNAP_BIT_HOME] = p.home_proximity_input;
        w[`SNAP_BIT_PIN_FOUR] = p.input_pin_four;
        w[`SNAP_BIT_PIN_FIVE] = p.input_pin_five;
        w[`SNAP_BIT_STO_A] = p.safe_torque_off_chan_a;
        w[`SNAP_BIT_STO_B] = p.safe_torque_off_chan_b;
        return w;
    endfunction

    function automatic logic [31:0] widen(input logic [POS_WIDTH-1:0] v);
        return 32'(signed'(v));
    endfunction

    // ---------------------------------------------------------------
    // Service handling
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.ans_valid = 1'b0;
        next_state.input_pin_snapshot = snapshot(pins_sync);
        next_state.launch = pins_sync.input_pin_four &
            ~input_four_function_param;
        if (req_valid) begin
            next_state.ans_valid = 1'b1;
            next_state.ans.status = `ANS_OK;
            next_state.ans.value = 32'h0000_0000;
            if (req.service == `SVC_GET_SINGLE) begin
                // Read answers with the current value
                if (req.object == `OBJ_PROBE_COMMAND) begin
                    next_state.ans.value = {16'h0000,
                        state.probe_command_word};
                end else if (req.object == `OBJ_PROBE_STATUS) begin
                    next_state.ans.value = {16'h0000, probe_status_word};
                end else if (req.object == `OBJ_ONE_RISE) begin
                    next_state.ans.value = widen(one_rise);
                end else if (req.object == `OBJ_ONE_FALL) begin
                    next_state.ans.value = widen(one_fall);
                end else if (req.object == `OBJ_TWO_RISE) begin
                    next_state.ans.value = widen(two_rise);
                end else if (req.object == `OBJ_TWO_FALL) begin
                    next_state.ans.value = widen(two_fall);
                end else if (req.object == `OBJ_INPUT_SNAPSHOT) begin
                    next_state.ans.value = state.input_pin_snapshot;
                end else begin
                    next_state.ans.status = `ANS_NO_OBJECT;
                end
            end else if (req.service == `SVC_SET_SINGLE) begin
                // Only the command word takes writes
                if (req.object == `OBJ_PROBE_COMMAND) begin
                    next_state.probe_command_word = req.value[15:0];
                end else if (req.object == `OBJ_PROBE_STATUS ||
                        req.object == `OBJ_ONE_RISE ||
                        req.object == `OBJ_ONE_FALL ||
                        req.object == `OBJ_TWO_RISE ||
                        req.object == `OBJ_TWO_FALL ||
                        req.object == `OBJ_INPUT_SNAPSHOT) begin
                    next_state.ans.status = `ANS_NOT_SETTABLE;
                end else begin
                    next_state.ans.status = `ANS_NO_OBJECT;
                end
            end else begin
                next_state.ans.status = `ANS_NOT_SUPPORTED;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
            // Volatile command word, zero from reset
            state.probe_command_word <= `PROBE_COMMAND_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign ans_valid = state.ans_valid;
    assign ans = state.ans;
    assign motion_launch_input = state.launch;

endmodule

`default_nettype wire

// *** bench/net_controller.sv ***
// Model of the network controller issuing get and set services.
// Assumes the block answers exactly one edge after taking a request.
`timescale 1ns/1ns
`default_nettype none

module net_controller
    import probe_latch_pkg::*;
(
    // Clock
    input wire logic clock,
    // Answer from the block
    input wire logic ans_valid,
    input wire answer_t ans,
    // Request to the block
    output logic req_valid,
    output request_t req
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // Released fields are inverted so a stale value never looks fresh
    task automatic access(input logic [7:0] svc, input logic [15:0] obj,
            input logic [31:0] val, output answer_t got, output logic seen);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= {svc, obj, val};
        @(posedge clock);
        req_valid <= 1'b0;
        req <= ~req;
        // Answer taken at the edge where it stands, not after it
        @(posedge clock);
        seen = ans_valid;
        got = ans;
    endtask
endmodule
`default_nettype wire

// *** bench/probe_latch_asserts.sv ***
// Checker for the probe latch answer path and pin snapshot.
// Sees only the top ports; bound to every probe_latch instance.
`timescale 1ns/1ns
`default_nettype none
`include "probe_latch_params.svh"

module probe_latch_asserts
    import probe_latch_pkg::*;
#(
    parameter int POS_WIDTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request and answer
    input wire logic req_valid,
    input wire request_t req,
    input wire logic ans_valid,
    input wire answer_t ans,
    // Position and pins
    input wire logic signed [POS_WIDTH-1:0] actual_position,
    input wire pins_t pins,
    input wire logic input_four_function_param,
    input wire logic motion_launch_input
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic get, set, known;
    logic [15:0] cmd;
    logic [31:0] snap;
    assign get = req_valid && req.service == `SVC_GET_SINGLE;
    assign set = req_valid && req.service == `SVC_SET_SINGLE;
    assign known = req.object inside
        {[`OBJ_PROBE_COMMAND:`OBJ_TWO_FALL], `OBJ_INPUT_SNAPSHOT};
    assign snap = {6'h00, pins.safe_torque_off_chan_b,
        pins.safe_torque_off_chan_a, 2'h0, pins.input_pin_five,
        pins.input_pin_four, 17'h00000, pins.home_proximity_input,
        pins.forward_stroke_end_input, pins.reverse_stroke_end_input};
    // Shadow of the last accepted command write
    always_ff @(posedge clock) begin
        if (rst) begin
            cmd <= 16'h0000;
        end else if (set && req.object == `OBJ_PROBE_COMMAND) begin
            cmd <= req.value[15:0];
        end
    end

    property p_answer; req_valid |=> ans_valid; endproperty
    a_answer: assert property (p_answer)
        else $error("request without answer");
    property p_quiet; !req_valid |=> !ans_valid; endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without request");
    property p_hold; !ans_valid |-> $stable(ans); endproperty
    a_hold: assert property (p_hold)
        else $error("answer changed between answers");
    property p_get_ok; get && known |=> ans.status == `ANS_OK; endproperty
    a_get_ok: assert property (p_get_ok)
        else $error("get of known object refused");
    property p_set_ro;
        set && known && req.object != `OBJ_PROBE_COMMAND
            |=> ans.status == `ANS_NOT_SETTABLE;
    endproperty
    a_set_ro: assert property (p_set_ro)
        else $error("set of read-only object not refused");
    property p_cmd;
        get && req.object == `OBJ_PROBE_COMMAND
            |=> ans.value == {16'h0000, cmd};
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("command word read-back wrong");
    property p_snap;
        ($stable(pins))[*5] ##0 (get && req.object == `OBJ_INPUT_SNAPSHOT)
            |=> (ans.value & 32'h0330_0007) == $past(snap);
    endproperty
    a_snap: assert property (p_snap)
        else $error("snapshot does not match pins");
    property p_launch;
        (!input_four_function_param && $stable(pins.input_pin_four))[*5]
            |-> motion_launch_input == pins.input_pin_four;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch output does not follow pin four");

    c_set: cover property (set && req.object == `OBJ_PROBE_COMMAND);
    c_snap: cover property (get && req.object == `OBJ_INPUT_SNAPSHOT);
    c_launch: cover property (motion_launch_input);
endmodule

bind probe_latch probe_latch_asserts #(.POS_WIDTH(POS_WIDTH)) checker_inst (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .ans_valid(ans_valid), .ans(ans), .actual_position(actual_position),
    .pins(pins), .input_four_function_param(input_four_function_param),
    .motion_launch_input(motion_launch_input)
);
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the probe latch block.
// Assumes the controller model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "probe_latch_params.svh"

module tb
    import probe_latch_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid, ans_valid, launch, seen;
    logic param = 1'b1;
    logic signed [31:0] position = 32'h0000_0000;
    request_t req;
    answer_t ans, got;
    pins_t pins = '0;
    pins_t stim;
    logic [31:0] seed = 32'h2596;
    logic [31:0] v, e;
    localparam logic [31:0] LO = 32'h0000_0007;
    localparam logic [31:0] HI = 32'h0330_0000;
    localparam logic [7:0] WR = `SVC_SET_SINGLE;
    localparam logic [7:0] RD = `SVC_GET_SINGLE;
    int err_total = 0;
    int check_count = 0;

    always #2 clock = ~clock;

    probe_latch #(.POS_WIDTH(32)) DUT (
        .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
        .ans_valid(ans_valid), .ans(ans), .actual_position(position),
        .pins(pins), .input_four_function_param(param),
        .motion_launch_input(launch)
    );
    net_controller ctl (
        .clock(clock), .ans_valid(ans_valid), .ans(ans),
        .req_valid(req_valid), .req(req)
    );

    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] snap_of(input pins_t s);
        return {6'h00, s.safe_torque_off_chan_b, s.safe_torque_off_chan_a,
            2'h0, s.input_pin_five, s.input_pin_four, 17'h00000,
            s.home_proximity_input, s.forward_stroke_end_input,
            s.reverse_stroke_end_input};
    endfunction
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] act);
        check_count++;
        if (act !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic xfer(input logic [7:0] svc, input logic [15:0] obj,
            input logic [31:0] val, input logic [7:0] st);
        ctl.access(svc, obj, val, got, seen);
        check("ans_valid", 32'h1, {31'h0, seen});
        check("ans.status", {24'h0, st}, {24'h0, got.status});
    endtask
    task automatic get_chk(input logic [15:0] obj, input logic [31:0] exp);
        xfer(`SVC_GET_SINGLE, obj, 32'h0, `ANS_OK);
        check("ans.value", exp, got.value);
    endtask
    // Position is moved away after the window so a late capture shows
    task automatic cap(input logic two, input logic lvl,
            input logic [15:0] obj, input logic [31:0] pos,
            input logic [31:0] exp);
        @(posedge clock);
        position <= pos;
        if (two) begin
            pins.input_pin_five <= lvl;
        end else begin
            pins.input_pin_four <= lvl;
        end
        repeat (8) @(posedge clock);
        position <= next_rand();
        get_chk(obj, exp);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------
    // Sequence
    // ----------------
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int o = 16'h60B8; o <= 16'h60BD; o++) begin
            get_chk(o[15:0], 32'h0);
        end
        repeat (3) begin
            v = next_rand();
            xfer(`SVC_SET_SINGLE, `OBJ_PROBE_COMMAND, v, `ANS_OK);
            get_chk(`OBJ_PROBE_COMMAND, {16'h0, v[15:0]});
        end
        v = 32'h0000_FFFF;
        xfer(WR, `OBJ_PROBE_COMMAND, v, `ANS_OK);
        get_chk(`OBJ_PROBE_COMMAND, 32'hFFFF);
        xfer(WR, `OBJ_ONE_RISE, v, `ANS_NOT_SETTABLE);
        xfer(WR, `OBJ_PROBE_STATUS, v, `ANS_NOT_SETTABLE);
        xfer(RD, 16'h60BE, 32'h0, `ANS_NO_OBJECT);
        xfer(8'h4C, `OBJ_PROBE_COMMAND, v, `ANS_NOT_SUPPORTED);
        get_chk(`OBJ_ONE_RISE, 32'h0);
        get_chk(`OBJ_PROBE_STATUS, 32'h0101);
        e = 32'h8000_0000;
        cap(1'b0, 1'b1, `OBJ_ONE_RISE, e, e);
        v = next_rand();
        cap(1'b0, 1'b0, `OBJ_ONE_FALL, v, v);
        v = 32'h7FFF_FFFF;
        cap(1'b1, 1'b1, `OBJ_TWO_RISE, v, v);
        v = next_rand();
        cap(1'b1, 1'b0, `OBJ_TWO_FALL, v, v);
        get_chk(`OBJ_ONE_RISE, e);
        get_chk(`OBJ_PROBE_STATUS, 32'h0707);
        @(posedge clock);
        param <= 1'b0;
        cap(1'b0, 1'b1, `OBJ_ONE_RISE, next_rand(), e);
        check("launch", 32'h1, {31'h0, launch});
        for (int i = 0; i < 6; i++) begin
            v = next_rand();
            stim = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : v[6:0];
            @(posedge clock);
            pins <= stim;
            repeat (5) @(posedge clock);
            xfer(RD, `OBJ_INPUT_SNAPSHOT, 32'h0, `ANS_OK);
            e = snap_of(stim);
            check("snap_lo", e & LO, got.value & LO);
            check("snap_home", e & 32'h4, got.value & 32'h4);
            check("snap_hi", e & HI, got.value & HI);
            check("launch", {31'h0, stim[3]}, {31'h0, launch});
        end
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        get_chk(`OBJ_ONE_FALL, 32'h0);
        end_of_test();
    end

    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
